// ---- hdl/rsr_pkg.sv ----
// Package for the reset and stop-recovery controller.
// Assumes a single 20 MHz clock domain and a synchronous reset.
package rsr_pkg;
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned OSC_CYCLES = 50;
  localparam int unsigned SYS_CYCLES = 16;
  localparam int unsigned HOLD_MIN_OSC = 66;
  localparam int unsigned PIN_FILT_CYCLES = 4;
  localparam logic [6:0] CNT_W_ZERO = 7'h00;
  localparam logic [6:0] OSC_LAST = 7'(OSC_CYCLES - 1);
  localparam logic [6:0] SYS_LAST = 7'(SYS_CYCLES - 1);
  localparam logic [6:0] HOLD_LAST = 7'(HOLD_MIN_OSC - 1);
  localparam logic [2:0] FILT_LAST = 3'(PIN_FILT_CYCLES - 1);
  localparam logic [31:0] RESET_VECTOR_ADDR = 32'h0000_0004;
  localparam int unsigned GPIO_W = 16;
  localparam int unsigned PWM_W = 6;

  // Cause flags, bit order power_on, stop, watchdog, pin, fault, software
  typedef struct packed {
    logic power_on;
    logic stop;
    logic watchdog;
    logic external_pin;
    logic fault;
    logic software;
  } rsr_cause_type;
  localparam rsr_cause_type CAUSE_RESET = '{1'b1, 1'b0, 1'b0, 1'b0,
                                            1'b0, 1'b0};

  typedef struct packed {
    logic power_on;
    logic brownout;
    logic watchdog_timeout;
    logic pin_low;
    logic debug_req;
    logic fault;
    logic sw_req;
    logic sw_from_debug;
    logic gpio_wake;
  } rsr_req_type;

  typedef enum logic [4:0] {
    ST_RUN    = 5'h01,
    ST_HOLD   = 5'h02,
    ST_OSC    = 5'h04,
    ST_SYS    = 5'h08,
    ST_PINWT  = 5'h10
  } rsr_state_type;

  typedef struct packed {
    rsr_state_type state;
    logic [6:0] cnt;
    logic [6:0] total;
    logic [2:0] filt;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [GPIO_W-1:0] gpio_s1;
    logic [GPIO_W-1:0] gpio_s2;
    logic [GPIO_W-1:0] gpio_prev;
    logic [8:0] req_s1;
    logic [8:0] req_s2;
    logic stop_rec;
    logic keep_debug;
    logic pwm_hiz;
    rsr_cause_type cause;
  } rsr_regs_type;
endpackage

// ---- hdl/rsr_reset_ctrl.sv ----
// Reset and stop-mode recovery controller: gathers reset requests,
// sequences release, drives the open-drain reset pin, records causes.
// Assumes asynchronous request levels and pins, one 20 MHz clock that
// stands in for both oscillator and system clock.
//
// What this block does
// - Any listed request starts a full system reset
// - Stop mode wakes on watchdog or GPIO edge
// - System reset holds at least 66 oscillator cycles
// - Reset start makes GPIO inputs, pull-ups off
// - PWM high-Z first, then programmed off-state
// - Count 50 oscillator then 16 system cycles
// - CPU and peripherals inactive, oscillators keep running
// - Control registers load defined reset values
// - CPU fetches reset vector at 0004H after release
// - Power-on or brownout outranks every other source
// - Power-on cause flag set after power-on reset
// - Brownout holds reset, then full power-on sequence
// - Option bit selects brownout detection in stop
// - Watchdog reset when select bit set, flag set
// - Pin must stay low four cycles, filtered
// - Held pin releases 16 cycles after deassertion
// - Early pin release: device drives pin low
// - Open-drain pin low until latency elapses
// - Pin filter bypassed in stop mode
// - External-pin cause flag set after pin reset
// - Software bit starts reset, spares debug unit only if from debug
// - Each event records only its own cause; a debug request records none
// - Stop recovery sets stop, plus watchdog flag on watchdog wake
// - Fault reset sets fault cause flag
`timescale 1ns/1ns
module rsr_reset_ctrl
  import rsr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic power_on_low,
  input wire logic brownout_detector,
  input wire logic watchdog_timeout,
  input wire logic debug_reset_req,
  input wire logic fault_detect,
  input wire logic user_rst_wr,
  input wire logic user_rst_from_debug,
  input wire logic stop_mode,
  input wire logic watchdog_reset_select,
  input wire logic brownout_in_stop_enable,
  input wire logic [rsr_pkg::GPIO_W-1:0] gpio_pin,
  input wire logic [rsr_pkg::GPIO_W-1:0] gpio_wake_enable,
  input wire logic [rsr_pkg::PWM_W-1:0] pwm_off_state,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic cpu_reset,
  output logic periph_reset,
  output logic debug_reset,
  output logic sys_clk_enable,
  output logic option_load,
  output logic osc_run,
  output logic gpio_force_input,
  output logic gpio_pullup_off,
  output logic pwm_hiz,
  output logic pwm_force_off,
  output logic [rsr_pkg::PWM_W-1:0] pwm_off_value,
  output logic [31:0] reset_vector_addr,
  output logic [5:0] reset_cause_reg
);
  import rsr_pkg::*;

  rsr_regs_type r_r;
  rsr_regs_type r_nxt;

  rsr_req_type req;
  logic pin_low;
  logic bo_active;
  logic por_bo;
  logic sys_req;
  logic wake_req;
  logic gpio_edge;
  logic in_reset;
  logic pin_filtered;

  function automatic rsr_cause_type one_cause(input int unsigned idx);
    rsr_cause_type c;
    c = '0;
    case (idx)
      0: c.power_on = 1'b1;
      1: c.external_pin = 1'b1;
      2: c.watchdog = 1'b1;
      3: c.fault = 1'b1;
      default: c.software = 1'b1;
    endcase
    return c;
  endfunction

  always_comb begin
    // Synchronised request view
    req = rsr_req_type'(r_r.req_s2);
    pin_low = r_r.pin_s2[0];
    bo_active = req.brownout && (!stop_mode || brownout_in_stop_enable);
    por_bo = req.power_on || bo_active;
    gpio_edge = |((r_r.gpio_s2 ^ r_r.gpio_prev) & gpio_wake_enable);
    // Four sampled low cycles in a row, or any low level in stop
    pin_filtered = pin_low
      && (stop_mode || r_r.filt == FILT_LAST);
    sys_req = por_bo || pin_filtered || req.debug_req || req.fault
      || req.sw_req
      || (req.watchdog_timeout && watchdog_reset_select && !stop_mode);
    wake_req = stop_mode && (req.watchdog_timeout || gpio_edge);
    in_reset = (r_r.state != ST_RUN);

    r_nxt = r_r;
    r_nxt.req_s1 = {power_on_low, brownout_detector, watchdog_timeout,
                    !reset_pin_in, debug_reset_req, fault_detect,
                    user_rst_wr, user_rst_from_debug, 1'b0};
    r_nxt.req_s2 = r_r.req_s1;
    r_nxt.pin_s1 = {1'b0, !reset_pin_in};
    r_nxt.pin_s2 = r_r.pin_s1;
    r_nxt.gpio_s1 = gpio_pin;
    r_nxt.gpio_s2 = r_r.gpio_s1;
    r_nxt.gpio_prev = r_r.gpio_s2;
    if (pin_low && r_r.filt != FILT_LAST) begin
      r_nxt.filt = r_r.filt + 3'h1;
    end else if (!pin_low) begin
      r_nxt.filt = 3'h0;
    end
    if (r_r.total != HOLD_LAST) begin
      r_nxt.total = r_r.total + 7'h01;
    end

    if (por_bo) begin
      // Brownout or power-on pins the sequence at its start
      r_nxt.state = ST_HOLD;
      r_nxt.cnt = CNT_W_ZERO;
      r_nxt.total = CNT_W_ZERO;
      r_nxt.stop_rec = 1'b0;
      r_nxt.keep_debug = 1'b0;
      r_nxt.pwm_hiz = 1'b1;
      r_nxt.cause = one_cause(0);
    end else if (!in_reset && (sys_req || wake_req)) begin
      r_nxt.state = ST_OSC;
      r_nxt.cnt = CNT_W_ZERO;
      r_nxt.total = CNT_W_ZERO;
      r_nxt.stop_rec = !sys_req;
      r_nxt.keep_debug = req.sw_req && req.sw_from_debug;
      r_nxt.pwm_hiz = sys_req;
      r_nxt.cause = '0;
      if (!sys_req) begin
        r_nxt.cause.stop = 1'b1;
        r_nxt.cause.watchdog = req.watchdog_timeout;
      end else if (pin_filtered) begin
        r_nxt.cause = one_cause(1);
      end else if (req.watchdog_timeout) begin
        r_nxt.cause = one_cause(2);
      end else if (req.fault) begin
        r_nxt.cause = one_cause(3);
      end else if (req.sw_req) begin
        r_nxt.cause = one_cause(4);
      end
    end else begin
      unique case (r_r.state)
        ST_RUN: begin
        end
        ST_HOLD: begin
          r_nxt.state = ST_OSC;
        end
        ST_OSC: begin
          r_nxt.cnt = r_r.cnt + 7'h01;
          if (r_r.cnt == OSC_LAST) begin
            r_nxt.state = ST_SYS;
            r_nxt.cnt = CNT_W_ZERO;
            r_nxt.pwm_hiz = 1'b0;
          end
        end
        ST_SYS: begin
          // Own drive reads back as low, so the pin is only judged
          // after the time-out, once the drive has been let go
          r_nxt.cnt = r_r.cnt + 7'h01;
          if (r_r.cnt >= SYS_LAST && r_r.total == HOLD_LAST) begin
            r_nxt.state = ST_PINWT;
            r_nxt.cnt = CNT_W_ZERO;
          end
        end
        ST_PINWT: begin
          // Pin still held: restart the trailing 16-cycle count
          r_nxt.cnt = pin_low ? CNT_W_ZERO : r_r.cnt + 7'h01;
          if (!pin_low && r_r.cnt == SYS_LAST) begin
            r_nxt.state = ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r_r <= '{state: ST_HOLD, cnt: CNT_W_ZERO, total: CNT_W_ZERO,
               filt: 3'h0, pin_s1: 2'h0, pin_s2: 2'h0, gpio_s1: '0,
               gpio_s2: '0, gpio_prev: '0, req_s1: 9'h000,
               req_s2: 9'h000, stop_rec: 1'b0, keep_debug: 1'b0,
               pwm_hiz: 1'b1, cause: CAUSE_RESET};
    end else begin
      r_r <= r_nxt;
    end
  end

  always_comb begin
    // Drive pin low through reset except in ST_PINWT; open drain, never high
    reset_pin_out = 1'b0;
    reset_pin_oe = in_reset && r_r.state != ST_PINWT;
    cpu_reset = in_reset;
    periph_reset = in_reset && !r_r.stop_rec;
    debug_reset = in_reset && !r_r.stop_rec && !r_r.keep_debug;
    sys_clk_enable = !(r_r.state inside {ST_HOLD, ST_OSC});
    option_load = (r_r.state == ST_OSC);
    osc_run = 1'b1;
    gpio_force_input = in_reset && !r_r.stop_rec;
    gpio_pullup_off = in_reset && !r_r.stop_rec;
    pwm_hiz = r_r.pwm_hiz;
    pwm_force_off = in_reset && !r_r.stop_rec && !r_r.pwm_hiz;
    pwm_off_value = pwm_off_state;
    reset_vector_addr = RESET_VECTOR_ADDR;
    reset_cause_reg = r_r.cause;
  end
endmodule // rsr_reset_ctrl

// ---- sim/rsr_pin_model.sv ----
// Board side of the reset pin: pull-up plus a switch to ground.
// Assumes the device pulls low only while its enable is high.
`timescale 1ns/1ns
module rsr_pin_model (
  input wire logic ext_low,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic pin_lvl
);
  // Open drain wire, pull-up when nobody drives
  assign pin_lvl = !(ext_low || (dev_oe && !dev_out));
endmodule // rsr_pin_model

// ---- sim/rsr_reset_ctrl_bench.sv ----
// Bench for the reset controller: table of sources, then edge cases.
// Assumes the pin model and checker compile before this file.
`timescale 1ns/1ns
module rsr_reset_ctrl_bench;
  import rsr_pkg::*;
  localparam logic [13:0] ROWS [8] = '{14'h0808, 14'h0404, 14'h0202,
    14'h0101, 14'h0080, 14'h3010, 14'h2818, 14'h0060};
  logic clk, srst = 1'b1, pol = 1'b0, bod = 1'b0, wdt = 1'b0, dbg = 1'b0;
  logic fault_cause_flag = 1'b0, software_cause_flag = 1'b0, stp = 1'b0, wsel = 1'b1, ext_low = 1'b0;
  logic tg = 1'b0, pz, pin_lvl, pin_out, pin_oe, cpu_rst, per_rst;
  logic [GPIO_W-1:0] gpio = 16'h0000;
  logic [5:0] cause;
  int failures = 0, compares = 0, n, m;
  rsr_reset_ctrl dut (.clk(clk), .srst(srst), .power_on_low(pol),
    .brownout_detector(bod), .watchdog_timeout(wdt),
    .debug_reset_req(dbg), .fault_detect(fault_cause_flag), .user_rst_wr(software_cause_flag),
    .user_rst_from_debug(1'b0), .stop_mode(stp),
    .watchdog_reset_select(wsel), .brownout_in_stop_enable(1'b0),
    .gpio_pin(gpio), .gpio_wake_enable(16'h0001),
    .pwm_off_state(6'h2a), .reset_pin_in(pin_lvl),
    .reset_pin_out(pin_out), .reset_pin_oe(pin_oe), .cpu_reset(cpu_rst),
    .periph_reset(per_rst), .debug_reset(), .sys_clk_enable(),
    .option_load(), .osc_run(), .gpio_force_input(), .gpio_pullup_off(),
    .pwm_hiz(), .pwm_force_off(), .pwm_off_value(),
    .reset_vector_addr(), .reset_cause_reg(cause));
  rsr_pin_model pin (.ext_low(ext_low), .dev_oe(pin_oe),
    .dev_out(pin_out), .pin_lvl(pin_lvl));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic set(input logic [7:0] rq);
    {bod, tg, wdt, ext_low, fault_cause_flag, software_cause_flag, dbg, pol} = rq;
    if (tg) gpio = ~gpio;
  endtask
  // Request for hold cycles, then wait until reset is over
  task automatic go(input logic [7:0] rq, input int hold);
    int i;
    n = 0;
    m = 0;
    pz = 1'b0;
    set(rq);
    for (i = 0; i < hold + 400; i++) begin
      @(negedge clk);
      if (i == hold - 1) set(8'h00);
      if (cpu_rst === 1'b1) n++;
      if (cpu_rst === 1'b1 && i >= hold) m++;
      if (per_rst === 1'b1) pz = 1'b1;
      if (i == 9 && rq[4] && hold < 9) chk(pin_lvl, 0);
      if (i >= hold && n > 0 && cpu_rst === 1'b0) return;
    end
    failures++;
    close_out();
  endtask
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    go(8'h00, 1);
    chk(cause, 6'h20);
    chk(n >= 66, 1);
    foreach (ROWS[k]) begin
      stp = ROWS[k][13];
      go({1'b0, ROWS[k][12:6]}, 6);
      chk(cause, ROWS[k][5:0]);
      chk(n >= 66, 1);
      chk(pz, !stp);
      stp = 1'b0;
    end
    set(8'h10);
    repeat (3) @(negedge clk);
    wsel = 1'b0;
    set(8'h20);
    repeat (6) @(negedge clk);
    set(8'h00);
    repeat (10) @(negedge clk);
    chk(cpu_rst, 0);
    wsel = 1'b1;
    go(8'h10, 150);
    chk(m >= 16 && m <= 20, 1);
    chk(cause, 6'h04);
    go(8'h80, 100);
    chk(n >= 162, 1);
    chk(cause, 6'h20);
    close_out();
  end
endmodule // rsr_reset_ctrl_bench
bind rsr_reset_ctrl rsr_mon mon (.clk, .srst, .fault_detect, .cpu_reset,
  .reset_pin_oe, .reset_pin_out, .option_load, .sys_clk_enable,
  .osc_run, .reset_vector_addr);

// ---- sim/rsr_reset_ctrl_monitor.sv ----
// Port checker for the reset controller.
// Assumes it is bound to the controller from the bench.
`timescale 1ns/1ns
module rsr_mon (
  input wire logic clk,
  input wire logic srst,
  input wire logic fault_detect,
  input wire logic cpu_reset,
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic option_load,
  input wire logic sys_clk_enable,
  input wire logic osc_run,
  input wire logic [31:0] reset_vector_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] n_r;
  // Cycles spent in reset, saturating
  always_ff @(posedge clk) begin
    if (srst || !cpu_reset) n_r <= 8'h00;
    else if (n_r != 8'hff) n_r <= n_r + 8'h01;
  end
  sequence osc_end;
    option_load ##1 (!option_load && sys_clk_enable);
  endsequence
  vec_const_a: assert property (reset_vector_addr == 32'h0000_0004)
    else $error("reset vector wrong");
  osc_live_a: assert property (osc_run)
    else $error("oscillator stopped");
  pin_low_a: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("pin not driven low");
  oe_reset_a: assert property (reset_pin_oe |-> cpu_reset)
    else $error("pin driven outside reset");
  load_noclk_a: assert property (option_load |-> !sys_clk_enable)
    else $error("clock on during option load");
  osc_phase_a: assert property ($rose(option_load) |-> ##49 osc_end)
    else $error("option phase length wrong");
  hold_len_a: assert property ($fell(cpu_reset) |-> n_r >= 8'h42)
    else $error("reset too short");
  fault_go_a: assert property (!cpu_reset && $rose(fault_detect)
    |-> ##[1:4] cpu_reset) else $error("fault ignored");
endmodule // rsr_mon
